/* File: mode_ctrl_pkg.sv */
// Package for the fieldbus slave mode control block: register map,
// field positions, reset values, timing figures and carrier types.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus.
package mode_ctrl_pkg;

    // Clock
    localparam int unsigned CLK_PERIOD_NS   = 10;

    // Register byte addresses (set and clear ports by index times four)
    localparam logic [7:0]  SET_PORT_INDEX  = 8'h08;
    localparam logic [7:0]  CLR_PORT_INDEX  = 8'h09;
    localparam logic [7:0]  ADDR_SET_PORT   = 8'h20;
    localparam logic [7:0]  ADDR_CLR_PORT   = 8'h24;
    localparam logic [7:0]  ADDR_CFG_WORD   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS     = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h10;
    localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h14;
    localparam logic [7:0]  ADDR_WD_PRESET  = 8'h18;

    // Configuration word field positions
    localparam int unsigned CFG_TICK_BASE   = 9;
    localparam int unsigned CFG_REL_BASE    = 10;
    localparam int unsigned CFG_WATCHDOG_TEST_SELECT     = 11;
    localparam int unsigned CFG_PRM_BUF     = 12;
    localparam int unsigned CFG_CLEAR_MODE  = 13;

    // Reset values
    localparam logic [15:0] CFG_RESET       = 16'h0000;
    localparam logic [15:0] WD_PRESET_RESET = 16'hffff;
    localparam logic [2:0]  IRQ_MASK_RESET  = 3'h0;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Timing figures and derived cycle counts
    localparam int unsigned REL_SHORT_NS    = 1000;
    localparam int unsigned REL_LONG_US     = 1000;
    localparam int unsigned TICK_SHORT_US   = 1000;
    localparam int unsigned TICK_LONG_US    = 10000;
    localparam int unsigned TIMER_W         = 20;
    localparam int unsigned REL_SHORT_CYC   =
        (REL_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned REL_LONG_CYC    =
        (REL_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TICK_SHORT_CYC  =
        (TICK_SHORT_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned TICK_LONG_CYC   =
        (TICK_LONG_US * 1000) / CLK_PERIOD_NS;

    // Self-clearing and steady command bits of the control register
    typedef struct packed {
        logic app_watchdog_reload_cmd;   // bit 5
        logic swap_enable;               // bit 4
        logic force_prm_wait_cmd;        // bit 3
        logic go_offline_cmd;            // bit 2
        logic interrupt_end_cmd;         // bit 1
        logic leave_offline_cmd;         // bit 0
    } ctrl_bits_t;

    // Sticky interrupt events
    typedef struct packed {
        logic entered_offline;           // bit 2
        logic app_watchdog_expired;      // bit 1
        logic periodic_tick;             // bit 0
    } irq_bits_t;

    // Offline or passive idle
    typedef enum logic {
        ST_OFFLINE = 1'b0,
        ST_IDLE    = 1'b1
    } link_state_t;

endpackage

/* File: cycle_timer.sv */
// Down counter that loads a cycle count and flags its last cycle.
// Runs on the block clock; load has priority over counting.
`timescale 1ns/1ns
module cycle_timer #(
    parameter int unsigned W = 20
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         srst_i,
    // Control
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    // Status
    output logic              busy_o,
    output logic              done_o
);

    logic [W-1:0] count;

    // Load or count toward zero
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            count <= '0;
        end else if (load_i) begin
            count <= value_i;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    // Last cycle of a run, one pulse
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= !load_i && (count == {{(W-1){1'b0}}, 1'b1});
        end
    end

    assign busy_o = (count != '0);

endmodule // cycle_timer

/* File: mode_ctrl.sv */
// Mode control registers of a fieldbus slave controller behind AXI4-Lite.
// Assumes one 100 MHz clock and a synchronous active high reset; the
// request-busy and configuration-accept inputs come from same-clock logic.
// Functional notes
// RL1 - After end of interrupt, interrupt stays inactive 1 us or 1 ms.
// RL2 - Periodic tick interrupt every 1 ms, or every 10 ms if selected.
// RL3 - Host keeps watchdog test select at zero; writing one not allowed.
// RL4 - Parameter buffer bit routes parameter data to the special buffer.
// RL5 - Fail-safe clear bit zero means no special clear behaviour.
// RL6 - Host changes the configuration word only while offline.
// RL7 - Control register has set and clear ports, one bit each.
// RL8 - Leave offline: go passive idle, start timers, drop go offline.
// RL9 - End of interrupt drops interrupt output, bit clears itself.
// RL10 - Go offline finishes current request, goes offline, clears itself.
// RL11 - Force parameter wait sends state machine to await parameters.
// RL12 - Swap enable gates configuration buffer exchange on accept.
// RL13 - Watchdog reload loads the preset, then the bit clears itself.
// RL14 - Status bit zero reads offline as 0, passive idle as 1.
// RL15 - Writing zero at either port leaves the control bit unchanged.
// RL16 - Configuration word writes are ignored unless offline.
`timescale 1ns/1ns
module mode_ctrl #(
    parameter int unsigned REL_LONG  = mode_ctrl_pkg::REL_LONG_CYC,
    parameter int unsigned TICK_SHORT = mode_ctrl_pkg::TICK_SHORT_CYC,
    parameter int unsigned TICK_LONG = mode_ctrl_pkg::TICK_LONG_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    // AXI4-Lite write
    input  wire logic [7:0]  awaddr_i,
    input  wire logic        awvalid_i,
    output logic             awready_o,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wstrb_i,
    input  wire logic        wvalid_i,
    output logic             wready_o,
    output logic [1:0]       bresp_o,
    output logic             bvalid_o,
    input  wire logic        bready_i,
    // AXI4-Lite read
    input  wire logic [7:0]  araddr_i,
    input  wire logic        arvalid_i,
    output logic             arready_o,
    output logic [31:0]      rdata_o,
    output logic [1:0]       rresp_o,
    output logic             rvalid_o,
    input  wire logic        rready_i,
    // Slave engine
    input  wire logic        request_busy_i,
    input  wire logic        cfg_accept_i,
    output logic             bus_timers_start_o,
    output logic             prm_wait_req_o,
    output logic             cfg_swap_o,
    output logic             param_buffer_o,
    output logic             clear_mode_o,
    output logic             watchdog_test_select_o,
    // Interrupt
    output logic             irq_o
);
    import mode_ctrl_pkg::*;
    logic [7:0]         aw_addr;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic [15:0]        cfg_word, wd_preset, wd_count;
    logic               wr_go, ar_go, leave_now, offline_now, rd_clr_irq;
    logic               tick_busy, tick_done, hold_busy;
    logic [TIMER_W-1:0] tick_value, hold_value;
    ctrl_bits_t         ctrl, set_bits, clr_bits, auto_clr;
    irq_bits_t          irq_stat, irq_mask, irq_event;
    link_state_t        state;
    // Byte-lane merge of the captured write into a half-word register
    function automatic logic [15:0] merge(input logic [15:0] old);
        return {w_strb[1] ? w_data[15:8] : old[15:8],
                w_strb[0] ? w_data[7:0] : old[7:0]};
    endfunction
    // Write channel capture, address and data in either order
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            awready_o <= 1'b1;
            wready_o  <= 1'b1;
            aw_addr   <= 8'h00;
            w_data    <= 32'h0000_0000;
            w_strb    <= 4'h0;
        end else begin
            if (awvalid_i && awready_o) begin
                aw_addr   <= awaddr_i;
                awready_o <= 1'b0;
            end
            if (wvalid_i && wready_o) begin
                w_data   <= wdata_i;
                w_strb   <= wstrb_i;
                wready_o <= 1'b0;
            end
            if (bvalid_o && bready_i) begin
                awready_o <= 1'b1;
                wready_o  <= 1'b1;
            end
        end
    end
    assign wr_go = !awready_o && !wready_o && !bvalid_o;
    // Write response, error on unmapped or read-only address
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            bvalid_o <= 1'b0;
            bresp_o  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_o <= 1'b1;
            case (aw_addr)
                ADDR_CFG_WORD, ADDR_IRQ_MASK, ADDR_WD_PRESET,
                ADDR_SET_PORT, ADDR_CLR_PORT: bresp_o <= RESP_OKAY;
                default:                      bresp_o <= RESP_SLVERR;
            endcase
        end else if (bvalid_o && bready_i) begin
            bvalid_o <= 1'b0;
        end
    end

    // Configuration word, accepted only while offline
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cfg_word <= CFG_RESET;
        end else if (wr_go && aw_addr == ADDR_CFG_WORD
                     && state == ST_OFFLINE) begin // RL6 RL16
            cfg_word <= merge(cfg_word);
        end
    end
    // Mask and watchdog preset registers
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_mask  <= IRQ_MASK_RESET;
            wd_preset <= WD_PRESET_RESET;
        end else if (wr_go) begin
            if (aw_addr == ADDR_IRQ_MASK && w_strb[0]) begin
                irq_mask <= w_data[2:0];
            end
            if (aw_addr == ADDR_WD_PRESET) begin
                wd_preset <= merge(wd_preset);
            end
        end
    end

    // Ones written at the set and clear ports; zeros do nothing
    always_comb begin
        set_bits = '0;
        clr_bits = '0;
        if (wr_go && w_strb[0] && aw_addr == ADDR_SET_PORT) begin
            set_bits = w_data[5:0]; // RL7 RL15
        end
        if (wr_go && w_strb[0] && aw_addr == ADDR_CLR_PORT) begin
            clr_bits = w_data[5:0]; // RL7 RL15
        end
    end

    // Commands the device acts on this cycle and then drops
    assign leave_now   = ctrl.leave_offline_cmd && state == ST_OFFLINE;
    assign offline_now = ctrl.go_offline_cmd && !request_busy_i
                         && state == ST_IDLE; // RL10
    always_comb begin
        auto_clr = '0;
        auto_clr.interrupt_end_cmd       = ctrl.interrupt_end_cmd; // RL9
        auto_clr.force_prm_wait_cmd      = ctrl.force_prm_wait_cmd; // RL11
        auto_clr.app_watchdog_reload_cmd =
            ctrl.app_watchdog_reload_cmd; // RL13
        auto_clr.go_offline_cmd          = offline_now || leave_now; // RL8
        auto_clr.leave_offline_cmd       = offline_now;
    end
    // Control bits; a host set wins over a device clear
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ctrl <= '0;
        end else begin
            ctrl <= (ctrl & ~clr_bits & ~auto_clr) | set_bits;
        end
    end

    // Offline and passive idle state
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state <= ST_OFFLINE;
        end else if (leave_now) begin
            state <= ST_IDLE; // RL8
        end else if (offline_now) begin
            state <= ST_OFFLINE; // RL10
        end
    end

    // Command pulses toward the slave engine
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            bus_timers_start_o <= 1'b0;
            prm_wait_req_o     <= 1'b0;
            cfg_swap_o         <= 1'b0;
        end else begin
            bus_timers_start_o <= leave_now; // RL8
            prm_wait_req_o     <= ctrl.force_prm_wait_cmd; // RL11
            cfg_swap_o         <= cfg_accept_i && ctrl.swap_enable; // RL12
        end
    end

    // Mode levels from the configuration word
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            param_buffer_o         <= 1'b0;
            clear_mode_o           <= 1'b0;
            watchdog_test_select_o <= 1'b0;
        end else begin
            param_buffer_o         <= cfg_word[CFG_PRM_BUF]; // RL4
            clear_mode_o           <= cfg_word[CFG_CLEAR_MODE]; // RL5
            watchdog_test_select_o <= cfg_word[CFG_WATCHDOG_TEST_SELECT]; // RL3
        end
    end

    // Periodic tick, 1 ms or 10 ms
    assign tick_value = cfg_word[CFG_TICK_BASE]
                        ? TIMER_W'(TICK_LONG - 1)
                        : TIMER_W'(TICK_SHORT - 1); // RL2
    cycle_timer #(.W(TIMER_W)) u_tick (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .load_i    (!tick_busy),
        .value_i   (tick_value),
        .busy_o    (tick_busy),
        .done_o    (tick_done)
    );

    // Interrupt release hold time after end of interrupt
    assign hold_value = cfg_word[CFG_REL_BASE]
                        ? TIMER_W'(REL_LONG)
                        : TIMER_W'(REL_SHORT_CYC); // RL1
    cycle_timer #(.W(TIMER_W)) u_hold (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .load_i    (ctrl.interrupt_end_cmd),
        .value_i   (hold_value),
        .busy_o    (hold_busy),
        .done_o    ()
    );
    // Application watchdog, counts down on ticks while passive idle
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wd_count <= WD_PRESET_RESET;
        end else if (ctrl.app_watchdog_reload_cmd) begin
            wd_count <= wd_preset; // RL13
        end else if (tick_done && state == ST_IDLE && wd_count != 16'h0) begin
            wd_count <= wd_count - 16'h0001;
        end
    end

    // Events for the interrupt status
    always_comb begin
        irq_event = '0;
        irq_event.periodic_tick        = tick_done;
        irq_event.app_watchdog_expired = tick_done && state == ST_IDLE
            && wd_count == 16'h0001 && !ctrl.app_watchdog_reload_cmd;
        irq_event.entered_offline      = offline_now;
    end

    // Sticky status; a new event wins over the read clear
    assign rd_clr_irq = ar_go && araddr_i == ADDR_IRQ_STAT;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (rd_clr_irq ? irq_bits_t'(3'h0) : irq_stat)
                        | irq_event;
        end
    end

    // Level interrupt, forced low during the release hold
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_mask) && !hold_busy
                     && !ctrl.interrupt_end_cmd; // RL1 RL9
        end
    end

    // Read channel, one cycle answer
    assign ar_go = arvalid_i && arready_o;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            arready_o <= 1'b1;
            rvalid_o  <= 1'b0;
            rdata_o   <= 32'h0000_0000;
            rresp_o   <= RESP_OKAY;
        end else if (ar_go) begin
            arready_o <= 1'b0;
            rvalid_o  <= 1'b1;
            rresp_o   <= RESP_OKAY;
            case (araddr_i)
                ADDR_CFG_WORD:  rdata_o <= {16'h0000, cfg_word};
                ADDR_STATUS:    rdata_o <= {wd_count, 15'h0000,
                                            state}; // RL14
                ADDR_IRQ_STAT:  rdata_o <= {29'h0, irq_stat};
                ADDR_IRQ_MASK:  rdata_o <= {29'h0, irq_mask};
                ADDR_WD_PRESET: rdata_o <= {16'h0000, wd_preset};
                ADDR_SET_PORT,
                ADDR_CLR_PORT:  rdata_o <= {26'h0, ctrl};
                default: begin
                    rdata_o <= 32'h0000_0000;
                    rresp_o <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_o && rready_i) begin
            rvalid_o  <= 1'b0;
            arready_o <= 1'b1;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    a_cfg_locked: assert property ( // RL16
        state == ST_IDLE |=> $stable(cfg_word))
        else $error("config word changed while not offline");
    a_set_port_one: assert property ( // RL7
        wr_go && aw_addr == ADDR_SET_PORT && w_strb[0] && w_data[4]
        |=> ctrl.swap_enable)
        else $error("set port did not set swap enable");
    a_clr_port_one: assert property ( // RL7
        wr_go && aw_addr == ADDR_CLR_PORT && w_strb[0] && w_data[4]
        && !set_bits[4] |=> !ctrl.swap_enable)
        else $error("clear port did not clear swap enable");
    a_zero_write_kept: assert property ( // RL15
        wr_go && aw_addr == ADDR_CLR_PORT && !w_data[4]
        |=> ctrl.swap_enable == $past(ctrl.swap_enable))
        else $error("zero write changed swap enable");
    a_leave_offline: assert property ( // RL8
        leave_now |=> state == ST_IDLE && bus_timers_start_o
        && !ctrl.go_offline_cmd)
        else $error("leave offline not carried out");
    a_eoi_release: assert property ( // RL1
        ctrl.interrupt_end_cmd |=> !irq_o [*8])
        else $error("interrupt active during release hold");
    a_eoi_selfclr: assert property ( // RL9
        ctrl.interrupt_end_cmd && !set_bits.interrupt_end_cmd
        |=> !ctrl.interrupt_end_cmd)
        else $error("end of interrupt did not clear itself");
    a_go_offline: assert property ( // RL10
        ctrl.go_offline_cmd && request_busy_i |=> state == $past(state))
        else $error("went offline during a request");
    a_offline_done: assert property ( // RL10
        offline_now |=> state == ST_OFFLINE ##0 !ctrl.go_offline_cmd
        || $past(set_bits.go_offline_cmd))
        else $error("go offline not completed");
    a_prm_wait: assert property ( // RL11
        ctrl.force_prm_wait_cmd |=> prm_wait_req_o)
        else $error("parameter wait not requested");
    a_swap_gate: assert property ( // RL12
        cfg_accept_i && !ctrl.swap_enable |=> !cfg_swap_o)
        else $error("buffer swap without enable");
    a_wd_reload: assert property ( // RL13
        ctrl.app_watchdog_reload_cmd |=> wd_count == $past(wd_preset))
        else $error("watchdog not reloaded with preset");
    a_tick_period: assert property ( // RL2
        tick_done |-> ##1 !tick_done [*8])
        else $error("ticks too close together");
    a_status_state: assert property ( // RL14
        ar_go && araddr_i == ADDR_STATUS |=> rdata_o[0] == $past(state))
        else $error("status bit does not show state");
    c_leave_then_offline: cover property (leave_now ##[1:50] offline_now);
    c_eoi_with_irq: cover property (irq_o ##1 ctrl.interrupt_end_cmd);
    c_swap: cover property (cfg_swap_o);
    c_wd_expired: cover property (irq_event.app_watchdog_expired);
endmodule // mode_ctrl

/* File: host_axi.sv */
// Host processor model: AXI4-Lite master for the mode registers.
// Assumes a slave whose outputs are registered on the same clock.
`timescale 1ns/1ns
module host_axi (
    // Clock
    input  wire logic        ref_clk_i,
    // Write channels
    output logic [7:0]       awaddr_o,
    output logic             awvalid_o,
    input  wire logic        awready_i,
    output logic [31:0]      wdata_o,
    output logic [3:0]       wstrb_o,
    output logic             wvalid_o,
    input  wire logic        wready_i,
    input  wire logic [1:0]  bresp_i,
    input  wire logic        bvalid_i,
    output logic             bready_o,
    // Read channels
    output logic [7:0]       araddr_o,
    output logic             arvalid_o,
    input  wire logic        arready_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic [1:0]  rresp_i,
    input  wire logic        rvalid_i,
    output logic             rready_o
);
    import mode_ctrl_pkg::*;
    // Idle bus at time zero
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
        wstrb_o = 4'hf;
    end
    // One write; each channel held until its own ready
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] r);
        @(posedge ref_clk_i);
        awaddr_o <= a;
        wdata_o <= v;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (awready_i) awvalid_o <= 1'b0;
            if (wready_i) wvalid_o <= 1'b0;
        end while ((awvalid_o && !awready_i) || (wvalid_o && !wready_i));
        do @(posedge ref_clk_i); while (!bvalid_i);
        r = bresp_i;
        bready_o <= 1'b0;
    endtask
    // One read; rready held until rvalid is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] r);
        @(posedge ref_clk_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        do @(posedge ref_clk_i); while (!arready_i);
        arvalid_o <= 1'b0;
        do @(posedge ref_clk_i); while (!rvalid_i);
        v = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
    endtask
    // Config word write, watchdog test bit always kept clear
    task automatic cfg_wr(input logic [31:0] v);
        logic [1:0] r;
        wr(ADDR_CFG_WORD, v & ~(32'h1 << CFG_WATCHDOG_TEST_SELECT), r);
    endtask
endmodule // host_axi

/* File: tb.sv */
// Self-checking bench for the mode control block.
// Assumes shrunk timer parameters and the host model on the bus.
`timescale 1ns/1ns
module tb;
    import mode_ctrl_pkg::*;
    localparam int RL = 20, TS = 50, TL = 80;
    logic        ref_clk_i, srst_i, request_busy_i, cfg_accept_i, irq_o;
    logic        awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o;
    logic        bready_i, arvalid_i, arready_o, rvalid_o, rready_i;
    logic        bus_timers_start_o, prm_wait_req_o, cfg_swap_o;
    logic        param_buffer_o, clear_mode_o, watchdog_test_select_o;
    logic [7:0]  awaddr_i, araddr_i;
    logic [31:0] wdata_i, rdata_o, d;
    logic [3:0]  wstrb_i;
    logic [1:0]  bresp_o, rresp_o, r;
    int          err_total, checks, cyc, n_start, n_prm, n_swap, t0;

    mode_ctrl #(.REL_LONG(RL), .TICK_SHORT(TS), .TICK_LONG(TL)) i_dut (.*);
    host_axi i_host (.ref_clk_i, .awaddr_o(awaddr_i), .awvalid_o(awvalid_i),
        .awready_i(awready_o), .wdata_o(wdata_i), .wstrb_o(wstrb_i),
        .wvalid_o(wvalid_i), .wready_i(wready_o), .bresp_i(bresp_o),
        .bvalid_i(bvalid_o), .bready_o(bready_i), .araddr_o(araddr_i),
        .arvalid_o(arvalid_i), .arready_i(arready_o), .rdata_i(rdata_o),
        .rresp_i(rresp_o), .rvalid_i(rvalid_o), .rready_o(rready_i));

    // Clock, cycle count and strobe counters
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        n_start <= n_start + int'(bus_timers_start_o === 1'b1);
        n_prm <= n_prm + int'(prm_wait_req_o === 1'b1);
        n_swap <= n_swap + int'(cfg_swap_o === 1'b1);
    end
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input string n);
        i_host.rd(a, d, r);
        chk(n, e, d);
        chk("rresp", 32'(RESP_OKAY), 32'(r));
    endtask
    task automatic wrc(input logic [7:0] a, input logic [31:0] v,
                       input logic [1:0] e);
        i_host.wr(a, v, r);
        chk("bresp", 32'(e), 32'(r));
    endtask
    task automatic wait_rise();
        while (irq_o !== 1'b0) @(posedge ref_clk_i);
        while (irq_o !== 1'b1) @(posedge ref_clk_i);
    endtask
    // Reset values and refused accesses
    task automatic t_reset();
        rdc(ADDR_CFG_WORD, 32'(CFG_RESET), "cfg");
        rdc(ADDR_STATUS, {WD_PRESET_RESET, 16'h0}, "status");
        rdc(ADDR_SET_PORT, 32'h0, "ctrl");
        rdc(ADDR_IRQ_MASK, 32'(IRQ_MASK_RESET), "mask");
        rdc(ADDR_WD_PRESET, 32'(WD_PRESET_RESET), "preset");
        i_host.rd(8'h08, d, r);
        chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
        wrc(8'h08, 32'h1, RESP_SLVERR);
        wrc(ADDR_STATUS, 32'h1, RESP_SLVERR);
    endtask
    // Config word fields while offline
    task automatic t_cfg();
        i_host.cfg_wr(32'h2e00);
        rdc(ADDR_CFG_WORD, 32'h2600, "cfg");
        chk("prm buf", 32'h0, param_buffer_o);
        chk("clear mode", 32'h1, clear_mode_o);
        chk("watchdog_test_select", 32'h0, watchdog_test_select_o);
        i_host.cfg_wr(32'h1600);
        rdc(ADDR_CFG_WORD, 32'h1600, "cfg");
        chk("prm buf", 32'h1, param_buffer_o);
        chk("clear mode", 32'h0, clear_mode_o);
    endtask
    // Leave offline, then a config write that must be ignored
    task automatic t_online();
        wrc(ADDR_SET_PORT, 32'h04, RESP_OKAY);
        rdc(ADDR_SET_PORT, 32'h04, "ctrl");
        wrc(ADDR_SET_PORT, 32'h01, RESP_OKAY);
        rdc(ADDR_CLR_PORT, 32'h01, "ctrl");
        i_host.rd(ADDR_STATUS, d, r);
        chk("idle", 32'h1, d & 32'h1);
        chk("timer starts", 32'h1, n_start);
        i_host.cfg_wr(32'h0); // Host breaks the offline-only habit here
        rdc(ADDR_CFG_WORD, 32'h1600, "cfg");
    endtask
    // Set and clear ports, swap gating, self-clearing commands
    task automatic t_ports();
        wrc(ADDR_SET_PORT, 32'h10, RESP_OKAY);
        wrc(ADDR_CLR_PORT, 32'h00, RESP_OKAY);
        wrc(ADDR_SET_PORT, 32'h00, RESP_OKAY);
        rdc(ADDR_CLR_PORT, 32'h11, "ctrl");
        for (int i = 0; i < 2; i++) begin
            cfg_accept_i <= 1'b1;
            @(posedge ref_clk_i);
            cfg_accept_i <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
            chk("swaps", 32'h1, n_swap);
            if (i == 0) wrc(ADDR_CLR_PORT, 32'h10, RESP_OKAY);
        end
        wrc(ADDR_WD_PRESET, 32'h0100, RESP_OKAY);
        wrc(ADDR_SET_PORT, 32'h28, RESP_OKAY);
        i_host.rd(ADDR_STATUS, d, r);
        chk("wd reload", 32'h1, d[31:16] inside {16'h0100, 16'h00ff});
        rdc(ADDR_SET_PORT, 32'h01, "ctrl");
        chk("prm wait", 32'h1, n_prm);
        repeat (TL + 10) @(posedge ref_clk_i);
        chk("masked irq", 32'h0, irq_o);
        wrc(ADDR_IRQ_MASK, 32'h1, RESP_OKAY);
    endtask
    // Tick period, then release hold after end of interrupt
    task automatic t_round(input int tick, input int hold);
        i_host.rd(ADDR_IRQ_STAT, d, r);
        wait_rise();
        t0 = cyc;
        i_host.rd(ADDR_IRQ_STAT, d, r);
        chk("tick flag", 32'h1, d & 32'h1);
        wait_rise();
        chk("tick period", 32'(tick), 32'(cyc - t0));
        wrc(ADDR_SET_PORT, 32'h02, RESP_OKAY);
        repeat (2) @(posedge ref_clk_i);
        chk("irq released", 32'h0, irq_o);
        t0 = cyc;
        while (irq_o !== 1'b1) @(posedge ref_clk_i);
        chk("hold", 32'h1, cyc - t0 >= hold - 6 && cyc - t0 <= hold + 2);
        rdc(ADDR_SET_PORT, 32'h01, "ctrl");
    endtask
    // Go offline waits for the busy request, then second round
    task automatic t_offline();
        request_busy_i <= 1'b1;
        wrc(ADDR_SET_PORT, 32'h04, RESP_OKAY);
        repeat (10) @(posedge ref_clk_i);
        i_host.rd(ADDR_STATUS, d, r);
        chk("idle while busy", 32'h1, d & 32'h1);
        request_busy_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        i_host.rd(ADDR_STATUS, d, r);
        chk("offline", 32'h0, d & 32'h1);
        rdc(ADDR_SET_PORT, 32'h0, "ctrl");
        i_host.cfg_wr(32'h0);
        wrc(ADDR_SET_PORT, 32'h01, RESP_OKAY);
        t_round(TS, 100);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Hang guard, well past the expected run
    initial begin
        #200us;
        err_total++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        srst_i = 1'b1;
        request_busy_i = 1'b0;
        cfg_accept_i = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        t_reset();
        t_cfg();
        t_online();
        t_ports();
        t_round(TL, RL);
        t_offline();
        tally_and_finish();
    end
endmodule // tb
